// ### pkg/mdu_pkg.sv
package mdu_pkg;
  // Data word width of the core
  localparam int MDU_W = 16;
  // Iterations of one multiply or divide
  localparam int MDU_STEPS = 16;
  // Register offsets on the software port
  localparam logic [2:0] MDU_OFS_LOW = 3'h0;
  localparam logic [2:0] MDU_OFS_HIGH = 3'h1;
  localparam logic [2:0] MDU_OFS_CTRL = 3'h2;
  localparam logic [2:0] MDU_OFS_STAT = 3'h3;
  localparam logic [2:0] MDU_OFS_MASK = 3'h4;
  // Control register fields
  localparam int MDU_CTL_STEP_LSB = 0;
  localparam int MDU_CTL_INUSE = 4;
  localparam int MDU_CTL_PEND = 5;
  localparam int MDU_CTL_OP_LSB = 6;
  // Status and mask bit positions
  localparam int MDU_EV_DONE = 0;
  localparam int MDU_EV_OVF = 1;
  localparam int MDU_EV_ABORT = 2;
  localparam int MDU_EV_W = 3;
  // Values after reset
  localparam logic [15:0] MDU_RST_WORD = 16'h0000;
  localparam logic [31:0] MDU_RST_ADDR = 32'h0000_0000;
  localparam logic [2:0] MDU_RST_EV = 3'h0;

  // Operations, chosen by the instruction issued
  typedef enum logic [2:0] {
    MDU_MULS, MDU_UNSIGNED_MULTIPLY_INSTR, MDU_DIVS, MDU_DIVU, MDU_DIVLS, MDU_DIVLU
  } mdu_op_t;

  // One issued instruction
  typedef struct packed {
    mdu_op_t op;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [31:0] addr;
  } mdu_cmd_t;

  // Signed variants
  function automatic logic mdu_is_signed(input mdu_op_t op);
    return op == MDU_MULS || op == MDU_DIVS || op == MDU_DIVLS;
  endfunction

  // Divide variants
  function automatic logic mdu_is_div(input mdu_op_t op);
    return op != MDU_MULS && op != MDU_UNSIGNED_MULTIPLY_INSTR;
  endfunction

  // Magnitude of a word, signed or not
  function automatic logic [15:0] mdu_mag16(input logic [15:0] v,
                                            input logic sgn);
    return (sgn && v[15]) ? 16'(-v) : v;
  endfunction
endpackage

// ### hdl/mdu_engine.sv
`timescale 1ns/100ps
module mdu_engine
#(
  parameter int STEPS = mdu_pkg::MDU_STEPS
)
(
  input wire logic i_clk,                // Core clock
  input wire logic i_rst,                // Sync reset
  input wire logic i_start,              // Fresh start pulse
  input wire logic i_resume,             // Resume pulse
  input wire logic i_halt,               // Freeze for interrupt
  input wire logic [3:0] i_step,         // Step to resume at
  input wire mdu_pkg::mdu_op_t i_op,     // Operation
  input wire logic [31:0] i_md,          // Result register contents
  input wire logic [15:0] i_opa,         // Multiplicand
  input wire logic [15:0] i_opb,         // Multiplier or divisor
  output logic o_done,                   // Finished pulse
  output logic o_ovf,                    // Result exceeds 16 bits
  output logic [31:0] o_result,          // Final result
  output logic [3:0] o_step              // Current iteration
);
  import mdu_pkg::*;

  logic run_reg;          // Iterating
  logic [3:0] cnt_reg;    // Iteration index
  logic [32:0] w_reg;     // Partial product or remainder/quotient
  logic [15:0] m_reg;     // Multiplicand or divisor magnitude
  logic div_reg;          // Dividing
  logic sgn_reg;          // Signed variant
  logic negq_reg;         // Negate product or quotient
  logic negr_reg;         // Negate remainder
  logic povf_reg;         // Divide overflow known up front
  logic [32:0] w_next;    // Next partial value
  logic [32:0] sh;        // Shifted partial for divide
  logic [16:0] sum;       // Add step for multiply
  logic [16:0] rem;       // Trial subtract for divide
  logic [31:0] dvd;       // Extended dividend
  logic [31:0] dmag;      // Dividend magnitude
  logic [31:0] fin;       // Final signed result
  logic fovf;             // Final overflow

  // One add-shift or shift-subtract step per cycle
  always_comb
  begin
    sh = {w_reg[31:0], 1'b0};
    sum = w_reg[32:16] + (w_reg[0] ? {1'b0, m_reg} : 17'h0);
    rem = sh[32:16] - {1'b0, m_reg};
    if (div_reg)
    begin
      if (sh[32:16] >= {1'b0, m_reg})
        w_next = {rem, sh[15:1], 1'b1};
      else
        w_next = sh;
    end
    else
      w_next = {1'b0, sum, w_reg[15:1]};
  end

  // Dividend from the result register, widened for short divides
  always_comb
  begin
    if (i_op == MDU_DIVLS || i_op == MDU_DIVLU)
      dvd = i_md;
    else if (mdu_is_signed(i_op))
      dvd = {{16{i_md[15]}}, i_md[15:0]};
    else
      dvd = {16'h0000, i_md[15:0]};
    dmag = (mdu_is_signed(i_op) && dvd[31]) ? 32'(-dvd) : dvd;
  end

  // Sign fix and overflow test on the last partial value
  always_comb
  begin
    fin = w_next[31:0];
    fovf = 1'b0;
    if (div_reg)
    begin
      // (RULE9) quotient low remainder high
      fin[15:0] = negq_reg ? 16'(-w_next[15:0]) : w_next[15:0];
      fin[31:16] = negr_reg ? 16'(-w_next[31:16]) : w_next[31:16];
      fovf = povf_reg | (sgn_reg &
             (negq_reg ? (w_next[15:0] > 16'h8000) : w_next[15]));
    end
    else
    begin
      fin = negq_reg ? 32'(-w_next[31:0]) : w_next[31:0];
      // (RULE6) product wider than word
      fovf = sgn_reg ? (fin[31:16] != {16{fin[15]}})
                     : (fin[31:16] != 16'h0000);
    end
  end

  // Operand load and iteration
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      run_reg <= 1'b0;
      cnt_reg <= 4'h0;
      w_reg <= 33'h0;
      m_reg <= 16'h0000;
      div_reg <= 1'b0;
      sgn_reg <= 1'b0;
      negq_reg <= 1'b0;
      negr_reg <= 1'b0;
      povf_reg <= 1'b0;
    end
    else if (i_start)
    begin
      // (RULE5) signed or unsigned magnitudes
      run_reg <= 1'b1;
      cnt_reg <= 4'h0;
      div_reg <= mdu_is_div(i_op);
      sgn_reg <= mdu_is_signed(i_op);
      if (mdu_is_div(i_op))
      begin
        // (RULE8) dividend from result register
        w_reg <= {1'b0, dmag};
        m_reg <= mdu_mag16(i_opb, mdu_is_signed(i_op));
        negq_reg <= mdu_is_signed(i_op) & (dvd[31] ^ i_opb[15]);
        negr_reg <= mdu_is_signed(i_op) & dvd[31];
        povf_reg <= dmag[31:16] >=
                    mdu_mag16(i_opb, mdu_is_signed(i_op));
      end
      else
      begin
        w_reg <= {17'h0, mdu_mag16(i_opb, mdu_is_signed(i_op))};
        m_reg <= mdu_mag16(i_opa, mdu_is_signed(i_op));
        negq_reg <= mdu_is_signed(i_op) & (i_opa[15] ^ i_opb[15]);
        negr_reg <= 1'b0;
        povf_reg <= 1'b0;
      end
    end
    else if (i_resume)
    begin
      // Partial value was kept; step comes back from control
      run_reg <= 1'b1;
      cnt_reg <= i_step;
    end
    else if (run_reg && !i_halt)
    begin
      // (RULE1) iterative multi-cycle steps
      w_reg <= w_next;
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg == 4'(STEPS - 1))
        run_reg <= 1'b0;
    end
    else if (i_halt)
      run_reg <= 1'b0;
  end

  // Finished result, one pulse after the last step
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_done <= 1'b0;
      o_ovf <= 1'b0;
      o_result <= 32'h0000_0000;
    end
    else
    begin
      o_done <= run_reg && !i_halt && !i_start && !i_resume &&
                cnt_reg == 4'(STEPS - 1);
      if (run_reg && !i_halt && cnt_reg == 4'(STEPS - 1))
      begin
        o_result <= fin;
        o_ovf <= fovf;
      end
    end
  end

  assign o_step = cnt_reg;
endmodule

// ### hdl/mdu_top.sv
`timescale 1ns/100ps
// How it works
// (RULE1) Iterative multi-cycle multiply and divide
// (RULE2) Results in 32-bit register, two halves
// (RULE3) In-use set on half write or start
// (RULE4) In-use cleared on low half read
// (RULE5) Signed and unsigned variants per instruction
// (RULE6) Overflow flag when result exceeds 16 bits
// (RULE7) Software reads high half before low
// (RULE8) Dividend from result register; divisor from core
// (RULE9) Quotient low half, remainder high half
// (RULE10) Interrupt mid-op saves address, sets restart flag
// (RULE11) Return tests restart flag, refetches instruction
// (RULE12) Control register keeps resume information
// (RULE13) Software clears control before fresh operation
// (RULE14) Results and overflow change only at end
module mdu_top
#(
  parameter int STEPS = mdu_pkg::MDU_STEPS
)
(
  input wire logic i_clk,                 // Core clock
  input wire logic i_rst,                 // Sync reset, high
  input wire logic [2:0] i_addr,          // Register address
  input wire logic [15:0] i_wdata,        // Write data
  input wire logic i_wr,                  // Write strobe
  input wire logic i_rd,                  // Read strobe
  output logic [15:0] o_rdata,            // Read data, next cycle
  input wire logic i_cmd_valid,           // Instruction issued
  input wire mdu_pkg::mdu_cmd_t i_cmd,    // Instruction and operands
  output logic o_busy,                    // Operation in progress
  output logic o_done,                    // Operation finished pulse
  output logic o_ovf_flag,                // Overflow status flag
  output logic o_in_use,                  // Result register in use
  input wire logic i_irq_take,            // Core takes an interrupt
  output logic o_abort,                   // Operation halted pulse
  output logic o_restart_flag,            // Restart flag for status
  output logic [31:0] o_ret_addr,         // Address to push
  input wire logic i_return_from_interrupt,                // Return from interrupt
  input wire logic i_return_from_interrupt_restart,        // Popped restart flag
  input wire logic [31:0] i_return_from_interrupt_addr,    // Popped return address
  output logic o_refetch,                 // Refetch pulse
  output logic [31:0] o_refetch_addr,     // Address to refetch
  output logic o_irq                      // Interrupt request level
);
  import mdu_pkg::*;

  // Result register halves
  logic [15:0] low_reg;
  logic [15:0] high_reg;
  // Control register state
  logic in_use_reg;
  logic pend_reg;
  logic [3:0] step_reg;
  mdu_op_t op_reg;
  // Address of the running instruction
  logic [31:0] cur_addr_reg;
  // Sticky events and their mask
  logic [MDU_EV_W-1:0] stat_reg;
  logic [MDU_EV_W-1:0] mask_reg;
  logic [MDU_EV_W-1:0] stat_next;
  logic [MDU_EV_W-1:0] ev_set;
  // Decoded strobes
  logic wr_low;
  logic wr_high;
  logic wr_ctrl;
  logic rd_low;
  // Command handling
  logic accept;
  logic resume;
  logic start;
  logic abort;
  // Engine outputs
  logic eng_done;
  logic eng_ovf;
  logic [31:0] eng_result;
  logic [3:0] eng_step;

  // Register strobe decode
  always_comb
  begin
    wr_low = i_wr && i_addr == MDU_OFS_LOW;
    wr_high = i_wr && i_addr == MDU_OFS_HIGH;
    wr_ctrl = i_wr && i_addr == MDU_OFS_CTRL;
    rd_low = i_rd && i_addr == MDU_OFS_LOW;
  end

  // Commands are refused while an operation runs
  always_comb
  begin
    accept = i_cmd_valid && !o_busy;
    // (RULE12) resume only the same pending operation
    resume = accept && pend_reg && op_reg == i_cmd.op;
    // (RULE13) cleared control means fresh start
    start = accept && !resume;
    // A finishing operation is not aborted
    abort = i_irq_take && o_busy && !eng_done;
  end

  // Iterative datapath
  mdu_engine #(
    .STEPS(STEPS)
  ) u_engine (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(start),
    .i_resume(resume),
    .i_halt(abort),
    .i_step(step_reg),
    .i_op(i_cmd.op),
    .i_md({high_reg, low_reg}),
    .i_opa(i_cmd.opa),
    .i_opb(i_cmd.opb),
    .o_done(eng_done),
    .o_ovf(eng_ovf),
    .o_result(eng_result),
    .o_step(eng_step)
  );

  // Result register halves
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      low_reg <= MDU_RST_WORD;
      high_reg <= MDU_RST_WORD;
    end
    else if (eng_done)
    begin
      // (RULE14) update only at completion
      // (RULE2) result into both halves
      low_reg <= eng_result[15:0];
      high_reg <= eng_result[31:16];
    end
    else
    begin
      // Software loads, e.g. a dividend before a divide
      if (wr_low)
        low_reg <= i_wdata;
      if (wr_high)
        high_reg <= i_wdata;
    end
  end

  // In-use flag: a set in the same cycle as a clear wins
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      in_use_reg <= 1'b0;
    // (RULE3) half written or op started
    else if (wr_low || wr_high || accept)
      in_use_reg <= 1'b1;
    // (RULE4) low half read clears
    else if (rd_low)
      in_use_reg <= 1'b0;
    else if (wr_ctrl)
      in_use_reg <= i_wdata[MDU_CTL_INUSE];
  end

  // Resume information in the control register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pend_reg <= 1'b0;
      step_reg <= 4'h0;
      op_reg <= MDU_MULS;
    end
    else if (abort)
    begin
      // (RULE12) keep op and step for re-execution
      pend_reg <= 1'b1;
      step_reg <= eng_step;
    end
    else if (accept)
    begin
      pend_reg <= 1'b0;
      op_reg <= i_cmd.op;
    end
    else if (wr_ctrl)
    begin
      // Restoring a saved word brings a halted op back
      pend_reg <= i_wdata[MDU_CTL_PEND];
      step_reg <= i_wdata[MDU_CTL_STEP_LSB +: 4];
      op_reg <= mdu_op_t'(i_wdata[MDU_CTL_OP_LSB +: 3]);
    end
  end

  // Busy and completion toward the core
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      cur_addr_reg <= MDU_RST_ADDR;
    end
    else
    begin
      o_done <= eng_done;
      if (accept)
      begin
        o_busy <= 1'b1;
        cur_addr_reg <= i_cmd.addr;
      end
      else if (eng_done || abort)
        o_busy <= 1'b0;
    end
  end

  // Overflow flag follows the last completed operation
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_ovf_flag <= 1'b0;
    // (RULE6) flag taken at completion
    else if (eng_done)
      o_ovf_flag <= eng_ovf;
  end

  // Interrupt entry while an operation runs
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_abort <= 1'b0;
      o_restart_flag <= 1'b0;
      o_ret_addr <= MDU_RST_ADDR;
    end
    else
    begin
      o_abort <= abort;
      if (abort)
      begin
        // (RULE10) push address, set restart
        o_restart_flag <= 1'b1;
        o_ret_addr <= cur_addr_reg;
      end
      else if (i_return_from_interrupt || accept)
        o_restart_flag <= 1'b0;
    end
  end

  // Return from interrupt: the popped flag decides a refetch
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_refetch <= 1'b0;
      o_refetch_addr <= MDU_RST_ADDR;
    end
    else
    begin
      // (RULE11) test flag before status restore
      o_refetch <= i_return_from_interrupt && i_return_from_interrupt_restart;
      if (i_return_from_interrupt && i_return_from_interrupt_restart)
        o_refetch_addr <= i_return_from_interrupt_addr;
    end
  end

  // Event sources and write-one-to-clear, set winning
  always_comb
  begin
    ev_set = '0;
    ev_set[MDU_EV_DONE] = eng_done;
    ev_set[MDU_EV_OVF] = eng_done && eng_ovf;
    ev_set[MDU_EV_ABORT] = abort;
    stat_next = stat_reg;
    if (i_wr && i_addr == MDU_OFS_STAT)
      stat_next = stat_reg & ~i_wdata[MDU_EV_W-1:0];
    stat_next = stat_next | ev_set;
  end

  // Status and mask registers
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      stat_reg <= MDU_RST_EV;
      mask_reg <= MDU_RST_EV;
    end
    else
    begin
      stat_reg <= stat_next;
      if (i_wr && i_addr == MDU_OFS_MASK)
        mask_reg <= i_wdata[MDU_EV_W-1:0];
    end
  end

  // Interrupt level, one cycle behind the status bits
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_irq <= 1'b0;
    else
      o_irq <= |(stat_reg & mask_reg);
  end

  // In-use mirrored for bit tests by the core
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_in_use <= 1'b0;
    else if (wr_low || wr_high || accept)
      o_in_use <= 1'b1;
    else if (rd_low)
      o_in_use <= 1'b0;
    else if (wr_ctrl)
      o_in_use <= i_wdata[MDU_CTL_INUSE];
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= MDU_RST_WORD;
    else if (i_rd)
    begin
      unique case (i_addr)
        MDU_OFS_LOW:
          o_rdata <= low_reg;
        // (RULE7) read first, in-use still set
        MDU_OFS_HIGH:
          o_rdata <= high_reg;
        MDU_OFS_CTRL:
        begin
          o_rdata <= MDU_RST_WORD;
          o_rdata[MDU_CTL_STEP_LSB +: 4] <= step_reg;
          o_rdata[MDU_CTL_INUSE] <= in_use_reg;
          o_rdata[MDU_CTL_PEND] <= pend_reg;
          o_rdata[MDU_CTL_OP_LSB +: 3] <= op_reg;
        end
        MDU_OFS_STAT:
          o_rdata <= {13'h0, stat_reg};
        MDU_OFS_MASK:
          o_rdata <= {13'h0, mask_reg};
        // Unmapped addresses read as zero
        default:
          o_rdata <= MDU_RST_WORD;
      endcase
    end
    else
      o_rdata <= MDU_RST_WORD;
  end
endmodule

// ### bench/mdu_top_props.sv
`timescale 1ns/100ps
module mdu_top_props
  import mdu_pkg::*;
#(
  parameter int STEPS = MDU_STEPS
)
(
  input wire logic i_clk,                // Core clock
  input wire logic i_rst,                // Sync reset
  input wire logic [2:0] i_addr,         // Register address
  input wire logic i_wr,                 // Write strobe
  input wire logic i_rd,                 // Read strobe
  input wire logic [15:0] o_rdata,       // Read data
  input wire logic i_cmd_valid,          // Instruction issued
  input wire logic o_busy,               // Operation running
  input wire logic o_done,               // Finished pulse
  input wire logic o_ovf_flag,           // Overflow flag
  input wire logic o_in_use,             // In-use flag
  input wire logic i_irq_take,           // Interrupt taken
  input wire logic o_abort,              // Halted pulse
  input wire logic i_return_from_interrupt,               // Return from interrupt
  input wire logic i_return_from_interrupt_restart,       // Popped restart flag
  input wire logic [31:0] i_return_from_interrupt_addr,   // Popped address
  input wire logic o_refetch,            // Refetch pulse
  input wire logic [31:0] o_refetch_addr // Refetch address
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_start_marks_use: assert property
    (i_cmd_valid && !o_busy |=> o_busy && o_in_use)
    else $error("start did not raise busy and in-use");
  a_op_ends_bounded: assert property
    (i_cmd_valid && !o_busy |-> ##[1:24] (o_done || o_abort))
    else $error("operation never finished");
  a_low_read_clears: assert property
    (i_rd && i_addr == MDU_OFS_LOW && !i_cmd_valid |=> !o_in_use)
    else $error("low half read left in-use set");
  a_half_write_sets: assert property
    (i_wr && (i_addr == MDU_OFS_LOW || i_addr == MDU_OFS_HIGH)
     |=> o_in_use)
    else $error("half write left in-use clear");
  a_rdata_idle_zero: assert property
    (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_abort_cause: assert property
    (o_abort |-> $past(i_irq_take) && !o_busy)
    else $error("halt without interrupt or still busy");
  a_refetch_addr: assert property
    (i_return_from_interrupt && i_return_from_interrupt_restart
     |=> o_refetch && o_refetch_addr == $past(i_return_from_interrupt_addr))
    else $error("refetch missing or wrong address");
  a_refetch_cause: assert property
    (o_refetch |-> $past(i_return_from_interrupt) && $past(i_return_from_interrupt_restart))
    else $error("refetch without restart return");
  a_ovf_only_end: assert property
    ($changed(o_ovf_flag) |-> o_done)
    else $error("overflow flag moved mid-operation");
endmodule

bind mdu_top mdu_top_props #(.STEPS(STEPS)) u_props (
  .i_clk, .i_rst, .i_addr, .i_wr, .i_rd, .o_rdata, .i_cmd_valid,
  .o_busy, .o_done, .o_ovf_flag, .o_in_use, .i_irq_take, .o_abort,
  .i_return_from_interrupt, .i_return_from_interrupt_restart, .i_return_from_interrupt_addr, .o_refetch, .o_refetch_addr
);

// ### bench/mdu_core_model.sv
`timescale 1ns/100ps
module mdu_core_model (
  input wire logic i_clk,             // Core clock
  input wire logic i_abort,           // Unit halted
  input wire logic i_restart_flag,    // Restart flag of handler
  input wire logic [31:0] i_ret_addr, // Address to push
  input wire logic i_go,              // Leave the handler
  output logic o_return_from_interrupt,                // Return pulse
  output logic o_return_from_interrupt_restart,        // Popped restart flag
  output logic [31:0] o_return_from_interrupt_addr     // Popped address
);
  logic [31:0] stack_reg; // One-deep return stack, enough for one level
  initial
  begin
    stack_reg = 32'h0000_0000;
    o_return_from_interrupt = 1'b0;
    o_return_from_interrupt_restart = 1'b0;
    o_return_from_interrupt_addr = 32'h0000_0000;
  end
  always @(posedge i_clk)
    if (i_abort)
      stack_reg <= i_ret_addr;
  always @(posedge i_clk)
  begin
    o_return_from_interrupt <= i_go;
    o_return_from_interrupt_restart <= i_go & i_restart_flag;
    // Idle address lines toggle so a stale value is never trusted
    o_return_from_interrupt_addr <= i_go ? stack_reg : ~o_return_from_interrupt_addr;
  end
endmodule

// ### bench/mdu_top_tb.sv
`timescale 1ns/100ps
module mdu_top_tb;
  import mdu_pkg::*;
  logic i_clk, i_rst, i_wr, i_rd, i_cmd_valid, i_irq_take, go;
  logic [2:0] i_addr;
  logic [15:0] i_wdata, o_rdata, d, h, l;
  mdu_cmd_t i_cmd;
  logic o_busy, o_done, o_ovf_flag, o_in_use, o_abort, o_restart_flag;
  logic o_refetch, o_irq, return_from_interrupt, return_from_interrupt_rs;
  logic [31:0] o_ret_addr, o_refetch_addr, return_from_interrupt_addr;
  int failures, samples_checked;

  mdu_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_busy(o_busy),
    .o_done(o_done), .o_ovf_flag(o_ovf_flag), .o_in_use(o_in_use),
    .i_irq_take(i_irq_take), .o_abort(o_abort),
    .o_restart_flag(o_restart_flag), .o_ret_addr(o_ret_addr),
    .i_return_from_interrupt(return_from_interrupt), .i_return_from_interrupt_restart(return_from_interrupt_rs), .i_return_from_interrupt_addr(return_from_interrupt_addr),
    .o_refetch(o_refetch), .o_refetch_addr(o_refetch_addr), .o_irq(o_irq));
  // Core side: pushes on halt, pops on return
  mdu_core_model u_core (.i_clk(i_clk), .i_abort(o_abort),
    .i_restart_flag(o_restart_flag), .i_ret_addr(o_ret_addr), .i_go(go),
    .o_return_from_interrupt(return_from_interrupt), .o_return_from_interrupt_restart(return_from_interrupt_rs), .o_return_from_interrupt_addr(return_from_interrupt_addr));

  initial i_clk = 1'b0;
  // 200 MHz core clock
  always #2.5 i_clk = ~i_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Bus write: one strobe cycle, then settle past the edge
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  // Bus read: data is valid only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask
  task automatic issue(input mdu_op_t op, input logic [15:0] a, b,
                       input logic [31:0] ad);
    @(posedge i_clk);
    i_cmd_valid <= 1'b1;
    i_cmd <= '{op, a, b, ad};
    @(posedge i_clk);
    i_cmd_valid <= 1'b0;
    #1;
  endtask
  // Bounded wait: 0 done, 1 halt, 2 refetch
  task automatic wait_ev(input int sel);
    int n;
    n = 0;
    // An unknown flag keeps waiting instead of passing as an event
    while ((sel == 0 ? o_done : sel == 1 ? o_abort : o_refetch) !== 1'b1)
    begin
      @(posedge i_clk);
      #1;
      n++;
      if (n > 40)
      begin
        failures++;
        stop_test();
      end
    end
  endtask
  task automatic t_op(input mdu_op_t op, input logic [15:0] a, b, hi, lo,
                      input logic [31:0] exp, input logic ov, full);
    wr(MDU_OFS_CTRL, 16'h0000);
    wr(MDU_OFS_HIGH, hi);
    chk(o_in_use, 1'b1);
    wr(MDU_OFS_LOW, lo);
    issue(op, a, b, 32'h0000_0100);
    chk(o_busy, 1'b1);
    rd(MDU_OFS_HIGH, h);
    chk(h, hi);
    wait_ev(0);
    chk(o_ovf_flag, ov);
    rd(MDU_OFS_HIGH, h);
    rd(MDU_OFS_LOW, l);
    chk(o_in_use, 1'b0);
    if (full)
      chk({h, l}, exp);
  endtask
  task automatic t_regs;
    rd(MDU_OFS_CTRL, d);
    chk(d, MDU_RST_WORD);
    // Unmapped place: writes vanish, reads give zero
    wr(3'h7, 16'hffff);
    rd(3'h7, d);
    chk(d, 16'h0000);
    chk(o_in_use, 1'b0);
  endtask
  task automatic t_ops;
    // every operation; high half ignored by short divide
    t_op(MDU_UNSIGNED_MULTIPLY_INSTR, 16'hffff, 16'hffff, 16'h0, 16'h0, 32'hfffe0001, 1, 1);
    t_op(MDU_MULS, 16'hffff, 16'h0002, 16'h0, 16'h0, 32'hfffffffe, 0, 1);
    t_op(MDU_MULS, 16'h4000, 16'h0004, 16'h0, 16'h0, 32'h00010000, 1, 1);
    t_op(MDU_DIVU, 16'h0, 16'h0007, 16'h5555, 16'h0064, 32'h0002000e, 0, 1);
    t_op(MDU_DIVS, 16'h0, 16'h0007, 16'h5555, 16'hff9c, 32'hfffefff2, 0, 1);
    t_op(MDU_DIVLU, 16'h0, 16'h0002, 16'h0001, 16'h0, 32'h00008000, 0, 1);
    t_op(MDU_DIVLS, 16'h0, 16'h0003, 16'hffff, 16'hfff0, 32'hfffffffb, 0, 1);
    // Overflow cases: zero divisor and too-wide quotient
    t_op(MDU_DIVU, 16'h0, 16'h0000, 16'h0, 16'h0064, 32'h0, 1, 0);
    t_op(MDU_DIVLU, 16'h0, 16'h0002, 16'h0002, 16'h0, 32'h0, 1, 0);
  endtask
  task automatic t_irq;
    wr(MDU_OFS_STAT, 16'h0007);
    wr(MDU_OFS_MASK, 16'h0000);
    t_op(MDU_UNSIGNED_MULTIPLY_INSTR, 16'h0002, 16'h0003, 16'h0, 16'h0, 32'h6, 0, 1);
    chk(o_irq, 1'b0);
    rd(MDU_OFS_STAT, d);
    chk(d, 16'h0001);
    wr(MDU_OFS_MASK, 16'h0001);
    @(posedge i_clk);
    #1;
    chk(o_irq, 1'b1);
    wr(MDU_OFS_STAT, 16'h0001);
    @(posedge i_clk);
    #1;
    chk(o_irq, 1'b0);
  endtask
  task automatic t_abort;
    wr(MDU_OFS_CTRL, 16'h0000);
    issue(MDU_UNSIGNED_MULTIPLY_INSTR, 16'h1234, 16'h0010, 32'h0000_2468);
    repeat (4) @(posedge i_clk);
    i_irq_take <= 1'b1;
    @(posedge i_clk);
    i_irq_take <= 1'b0;
    #1;
    wait_ev(1);
    chk(o_busy, 1'b0);
    chk(o_ret_addr, 32'h0000_2468);
    chk(o_restart_flag, 1'b1);
    rd(MDU_OFS_CTRL, d);
    chk(d[MDU_CTL_PEND], 1'b1);
    chk(d[MDU_CTL_OP_LSB +: 3], MDU_UNSIGNED_MULTIPLY_INSTR);
    wr(MDU_OFS_CTRL, 16'h0000);
    wr(MDU_OFS_CTRL, d);
    @(posedge i_clk);
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    #1;
    wait_ev(2);
    chk(o_refetch_addr, 32'h0000_2468);
    // Resumed instruction keeps its saved operands, so zeros here
    issue(MDU_UNSIGNED_MULTIPLY_INSTR, 16'h0000, 16'h0000, 32'h0000_2468);
    wait_ev(0);
    rd(MDU_OFS_HIGH, h);
    rd(MDU_OFS_LOW, l);
    chk({h, l}, 32'h0001_2340);
  endtask

  initial
  begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 3'h0;
    i_wdata = 16'h0000;
    i_cmd_valid = 1'b0;
    i_cmd = '0;
    i_irq_take = 1'b0;
    go = 1'b0;
    failures = 0;
    samples_checked = 0;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_regs();
    t_ops();
    t_irq();
    t_abort();
    stop_test();
  end
endmodule
